// ===== include/opl_pkg.sv
// Constants and types shared by the page memory loader and its byte FIFO.
// Assumes a single 250 MHz core clock and a synchronous active-high reset.
package opl_pkg;

	// Page memory geometry: 512 words of 12 bits.
	localparam int unsigned PAGE_DEPTH   = 512;
	localparam int unsigned PAGE_AW      = 9;
	localparam int unsigned WORD_W       = 12;

	// Incoming byte FIFO: eight data bits plus a first-of-transfer flag.
	localparam int unsigned FIFO_WIDTH   = 9;
	localparam int unsigned FIFO_DEPTH   = 16;
	localparam int unsigned FIFO_FIRST   = 8;

	// Serial bus register addresses seen by the loader.
	localparam logic [15:0] PAGE_BASE    = 16'h8000;
	localparam logic [15:0] PAGE_LAST    = 16'h81FF;
	localparam logic [15:0] FRAME_CTRL   = 16'h8400;
	localparam logic [15:0] BANK_SEL01   = 16'h8427;
	localparam logic [15:0] BANK_SEL23   = 16'h8428;

	// Field positions and reset values.
	localparam int unsigned CLEAR_BIT    = 3;
	localparam logic [7:0]  BANK01_RST   = 8'h10;
	localparam logic [7:0]  BANK23_RST   = 8'h32;
	localparam int unsigned BANK_LO_POS  = 0;
	localparam int unsigned BANK_HI_POS  = 4;

	// Page control codes in the character field.
	localparam logic [7:0]  SCREEN_END   = 8'h00;
	localparam logic [7:0]  LINE_END     = 8'h01;
	localparam logic [11:0] SCREEN_WORD  = 12'h000;

	// Last index of the clear sweep.
	localparam logic [8:0]  CLEAR_LAST   = 9'h1FF;

	// Loader byte-parser states, one-hot.
	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_ADLO  = 6'b000010,
		ST_ADHI  = 6'b000100,
		ST_ATTR  = 6'b001000,
		ST_DATA  = 6'b010000,
		ST_CLEAR = 6'b100000
	} opl_pstate_t;

endpackage : opl_pkg

// ===== verilog/opl_page_ram_loader.sv
// Page memory loader and walker for an on-screen-display generator, with
// the byte FIFO that sits between the serial front end and the parser.
// Assumes the front end has already matched the slave address and delivers
// each following byte with a flag on the first byte of a transfer.
//
// Notes on behaviour
// - Page memory holds 512 words of twelve bits.
// - Word holds character plus attribute, or control.
// - Each code takes one location; 512 maximum.
// - Frame control bit 3 write clears memory.
// - First window starts at location zero.
// - Skip-line attribute sits in low four bits.
// - Word after line end is skip-line.
// - Screen end 0x0000 ends line and window.
// - Screen end after line end means skip.
// - After screen end, codes form next window.
// - Transfer attribute attaches to each later code.
// - Line end and screen end attributes ignored; the code stores the line end attribute and the walker drives it on attrCode.
// - Width unlimited; blanking characters are hidden.
// - Top two code bits pick bank register.
// - Two bank registers hold four bank numbers.
// - After mid-line stop, first byte is attribute.
`timescale 1ns/100ps

// Synchronous FIFO with valid and ready on both sides.
module opl_byte_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int unsigned AW = $clog2(DEPTH);

	// Pointer and occupancy state of the FIFO.
	typedef struct packed {
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0]   count;
	} opl_fifo_state_t;

	opl_fifo_state_t        cur_r;   // Registered state.
	opl_fifo_state_t        cur_nxt; // Next state.
	logic [WIDTH-1:0]       store [DEPTH]; // Word storage.
	logic                   doPush;  // A word enters this cycle.
	logic                   doPop;   // A word leaves this cycle.

	assign inReady  = (cur_r.count != (AW+1)'(DEPTH));
	assign outValid = (cur_r.count != '0);
	assign outData  = store[cur_r.rdPtr];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	// Pointer and count update; count is honest so full and empty are exact.
	always_comb begin
		cur_nxt = cur_r;
		if (doPush) begin
			cur_nxt.wrPtr = cur_r.wrPtr + 1'b1;
		end
		if (doPop) begin
			cur_nxt.rdPtr = cur_r.rdPtr + 1'b1;
		end
		cur_nxt.count = cur_r.count + (AW+1)'(doPush) - (AW+1)'(doPop);
	end

	// State register and storage write.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cur_r <= '0;
		end else begin
			cur_r <= cur_nxt;
		end
		if (doPush) begin
			store[cur_r.wrPtr] <= inData;
		end
	end

endmodule : opl_byte_fifo

// Loader top: parses transfers, writes the page memory, walks it for display.
module opl_page_ram_loader
	import opl_pkg::*;
(
	input  wire logic                        core_clk,
	input  wire logic                        sys_rst,
	input  wire logic                        byteValid,
	input  wire logic [7:0]                  byteData,
	input  wire logic                        byteFirst,
	output logic                             byteReady,
	input  wire logic                        walkStart,
	input  wire logic [opl_pkg::PAGE_AW-1:0] walkStartAddr,
	input  wire logic                        walkNext,
	input  wire logic                        hBlank,
	output logic                             codeValid,
	output logic [7:0]                       charCode,
	output logic [3:0]                       attrCode,
	output logic [2:0]                       fontBank,
	output logic                             lineEnd,
	output logic                             screenEnd,
	output logic                             skipLine,
	output logic [7:0]                       skipCount,
	output logic                             charVisible,
	output logic                             windowIndex,
	output logic                             clearBusy
);
	import opl_pkg::*;

	// All control state of the loader.
	typedef struct packed {
		opl_pstate_t         st;       // Byte parser state.
		logic [15:0]         addr;     // Current bus register address.
		logic [3:0]          attr;     // Attribute of this transfer.
		logic                wrSkip;   // Next page byte is a skip-line.
		logic                midLine;  // Last transfer stopped mid-line.
		logic [PAGE_AW-1:0]  clrIdx;   // Clear sweep index.
		logic [7:0]          bank01;   // Bank numbers for selects 0 and 1.
		logic [7:0]          bank23;   // Bank numbers for selects 2 and 3.
		logic                full;     // Inverse of FIFO ready, as a flop.
		logic [PAGE_AW-1:0]  rdAddr;   // Walker read address.
		logic                rdGo;     // Read issued this cycle.
		logic                rdDone;   // Read data is valid.
		logic                rdSkip;   // Walker expects a skip-line.
		logic                oValid;   // Decoded word on the outputs.
		logic [7:0]          oCode;    // Character field.
		logic [3:0]          oAttr;    // Attribute field.
		logic [2:0]          oBank;    // Font bank of the character.
		logic                oLine;    // Line end decoded.
		logic                oScreen;  // Screen end decoded.
		logic                oSkip;    // Skip-line decoded.
		logic [7:0]          oSkipCnt; // Blank lines to insert.
		logic                oVis;     // Character lies outside blanking.
		logic                oWin;     // Window the word belongs to.
		logic                oClear;   // Clear sweep running.
	} opl_state_t;

	opl_state_t              cur_r;         // Registered state.
	opl_state_t              cur_nxt;       // Next state.
	logic [WORD_W-1:0]       pageMem [PAGE_DEPTH]; // Page memory.
	logic [WORD_W-1:0]       memRd;         // Registered read word.
	logic                    memWe;         // Page memory write strobe.
	logic [PAGE_AW-1:0]      memWa;         // Page memory write address.
	logic [WORD_W-1:0]       memWd;         // Page memory write word.
	logic                    fifoValid;     // Parser has a byte.
	logic [FIFO_WIDTH-1:0]   fifoData;      // Byte with first flag.
	logic                    fifoReady;     // Parser takes the byte.
	logic                    fifoInReady;   // FIFO has room.
	logic                    take;          // Byte consumed this cycle.
	logic [7:0]              inByte;        // Data part of the byte.

	// True when a bus address falls inside the page memory window.
	function automatic logic inPage(input logic [15:0] a);
		inPage = (a >= PAGE_BASE) && (a <= PAGE_LAST);
	endfunction : inPage

	// Font bank selected by the top two bits of a character code.
	function automatic logic [2:0] bankOf(input logic [7:0] code,
	                                      input logic [7:0] b01,
	                                      input logic [7:0] b23);
		logic [7:0] sel;
		sel = code[7] ? b23 : b01;
		bankOf = code[6] ? sel[BANK_HI_POS +: 3] : sel[BANK_LO_POS +: 3];
	endfunction : bankOf

	// The FIFO absorbs bytes while the parser stalls during a clear.
	opl_byte_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.inValid  (byteValid),
		.inData   ({byteFirst, byteData}),
		.inReady  (fifoInReady),
		.outValid (fifoValid),
		.outData  (fifoData),
		.outReady (fifoReady)
	);

	assign fifoReady = (cur_r.st != ST_CLEAR);
	assign take      = fifoValid && fifoReady;
	assign inByte    = fifoData[7:0];

	// Parser, clear sweep and walker next-state logic.
	always_comb begin
		cur_nxt = cur_r;
		memWe   = 1'b0;
		memWa   = cur_r.addr[PAGE_AW-1:0];
		memWd   = '0;
		cur_nxt.full = !fifoInReady;
		if (take && fifoData[FIFO_FIRST]) begin
			// A new transfer always restarts with the address low byte.
			cur_nxt.st = ST_ADHI;
			cur_nxt.addr = {8'h00, inByte};
		end else if (take) begin
			case (cur_r.st)
				ST_ADHI: begin
					cur_nxt.addr = {inByte, cur_r.addr[7:0]};
					if (inPage({inByte, cur_r.addr[7:0]})) begin
						cur_nxt.st = ST_ATTR;
					end else begin
						cur_nxt.st = ST_DATA;
					end
					if ({inByte, cur_r.addr[7:0]} == PAGE_BASE) begin
						cur_nxt.wrSkip = 1'b1;
					end
				end
				ST_ATTR: begin
					// First data byte of a page memory transfer is the attribute.
					cur_nxt.attr = inByte[3:0];
					cur_nxt.st = ST_DATA;
				end
				ST_DATA: begin
					cur_nxt.addr = cur_r.addr + 16'h0001;
					if (inPage(cur_r.addr)) begin
						// One location per code; past the end is dropped.
						memWe = 1'b1;
						if (cur_r.wrSkip) begin
							// Skip count high, attribute low.
							memWd = {inByte, cur_r.attr};
							cur_nxt.wrSkip = 1'b0;
							cur_nxt.midLine = 1'b1;
						end else if (inByte == SCREEN_END) begin
							// Ends line and window; next is a skip.
							memWd = SCREEN_WORD;
							cur_nxt.wrSkip = 1'b1;
							cur_nxt.midLine = 1'b0;
						end else if (inByte == LINE_END) begin
							memWd = {cur_r.attr, inByte};
							cur_nxt.wrSkip = 1'b1;
							cur_nxt.midLine = 1'b0;
						end else begin
							memWd = {cur_r.attr, inByte};
							cur_nxt.midLine = 1'b1;
						end
					end else if (cur_r.addr == FRAME_CTRL) begin
						if (inByte[CLEAR_BIT]) begin
							cur_nxt.st = ST_CLEAR;
							cur_nxt.clrIdx = '0;
							cur_nxt.oClear = 1'b1;
						end
					end else if (cur_r.addr == BANK_SEL01) begin
						cur_nxt.bank01 = inByte;
					end else if (cur_r.addr == BANK_SEL23) begin
						cur_nxt.bank23 = inByte;
					end
				end
				default: begin
					// Bytes outside a transfer are discarded.
					cur_nxt.st = ST_IDLE;
				end
			endcase
		end else if (cur_r.st == ST_CLEAR) begin
			// One location per cycle is zeroed; the FIFO holds new bytes.
			memWe = 1'b1;
			memWa = cur_r.clrIdx;
			memWd = '0;
			cur_nxt.clrIdx = cur_r.clrIdx + 1'b1;
			if (cur_r.clrIdx == CLEAR_LAST) begin
				cur_nxt.st = ST_DATA;
				cur_nxt.oClear = 1'b0;
			end
		end

		// Walker: one read per request, decoded one cycle after the data.
		cur_nxt.rdGo = 1'b0;
		cur_nxt.rdDone = cur_r.rdGo;
		if (walkStart) begin
			cur_nxt.rdAddr = walkStartAddr;
			cur_nxt.rdGo = 1'b1;
			cur_nxt.rdSkip = 1'b1;
			cur_nxt.oValid = 1'b0;
			cur_nxt.oWin = 1'b0;
		end else if (walkNext && cur_r.oValid) begin
			cur_nxt.rdAddr = cur_r.rdAddr + 1'b1;
			cur_nxt.rdGo = 1'b1;
			cur_nxt.oValid = 1'b0;
		end else if (cur_r.rdDone) begin
			cur_nxt.oValid = 1'b1;
			cur_nxt.oLine = 1'b0;
			cur_nxt.oScreen = 1'b0;
			cur_nxt.oSkip = 1'b0;
			cur_nxt.oSkipCnt = '0;
			cur_nxt.oCode = memRd[7:0];
			cur_nxt.oAttr = memRd[11:8];
			cur_nxt.oBank = bankOf(memRd[7:0], cur_r.bank01,
			                       cur_r.bank23);
			cur_nxt.oVis = 1'b0;
			cur_nxt.rdSkip = 1'b0;
			if (cur_r.rdSkip) begin
				// Even a zero word here is a skip count.
				cur_nxt.oSkip = 1'b1;
				cur_nxt.oSkipCnt = memRd[11:4];
				cur_nxt.oAttr = memRd[3:0];
			end else if (memRd == SCREEN_WORD) begin
				cur_nxt.oScreen = 1'b1;
				cur_nxt.rdSkip = 1'b1;
				cur_nxt.oWin = !cur_r.oWin;
			end else if (memRd[7:0] == LINE_END) begin
				cur_nxt.oLine = 1'b1;
				cur_nxt.rdSkip = 1'b1;
			end else begin
				// Characters in horizontal blanking are hidden.
				cur_nxt.oVis = !hBlank;
			end
		end
	end

	// Single state register of the loader.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cur_r <= '0;
			cur_r.st <= ST_IDLE;
			cur_r.bank01 <= BANK01_RST;
			cur_r.bank23 <= BANK23_RST;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	// Page memory with one write port and one registered read port.
	always_ff @(posedge core_clk) begin
		if (memWe) begin
			pageMem[memWa] <= memWd;
		end
		if (cur_r.rdGo) begin
			memRd <= pageMem[cur_r.rdAddr];
		end
	end

	// Outputs straight from the state register.
	assign byteReady   = !cur_r.full;
	assign codeValid   = cur_r.oValid;
	assign charCode    = cur_r.oCode;
	assign attrCode    = cur_r.oAttr;
	assign fontBank    = cur_r.oBank;
	assign lineEnd     = cur_r.oLine;
	assign screenEnd   = cur_r.oScreen;
	assign skipLine    = cur_r.oSkip;
	assign skipCount   = cur_r.oSkipCnt;
	assign charVisible = cur_r.oVis;
	assign windowIndex = cur_r.oWin;
	assign clearBusy   = cur_r.oClear;

endmodule : opl_page_ram_loader

// ===== testbench/opl_loader_sva.sv
// Assertion checker that watches the ports of the page memory loader.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/100ps
module opl_loader_sva (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       walkStart,
	input wire logic       walkNext,
	input wire logic       codeValid,
	input wire logic [7:0] charCode,
	input wire logic [3:0] attrCode,
	input wire logic       lineEnd,
	input wire logic       screenEnd,
	input wire logic       skipLine,
	input wire logic       charVisible,
	input wire logic       windowIndex,
	input wire logic       clearBusy
);
	logic [9:0] busyCnt_r; // Cycles spent so far in the clear sweep.

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// Counts the edges of one clear sweep so its length can be judged.
	always_ff @(posedge core_clk) begin
		if (sys_rst || !clearBusy) begin
			busyCnt_r <= 10'h000;
		end else begin
			busyCnt_r <= busyCnt_r + 10'h001;
		end
	end

	a_one_kind: assert property (codeValid |->
		$onehot0({lineEnd, screenEnd, skipLine}))
		else $error("Decoded word shows two kinds.");
	a_vis_char: assert property (codeValid && charVisible |->
		!lineEnd && !screenEnd && !skipLine)
		else $error("Control word marked visible.");
	a_out_hold: assert property (codeValid && !walkNext && !walkStart
		|=> codeValid && $stable(charCode) && $stable(attrCode))
		else $error("Decoded word changed without a request.");
	a_start_first: assert property (walkStart |-> ##3
		codeValid && skipLine && !windowIndex)
		else $error("Walk start did not decode a skip word.");
	a_next_step: assert property (walkNext && codeValid |=>
		!codeValid ##2 codeValid)
		else $error("Next word did not arrive on time.");
	a_clear_len: assert property ($fell(clearBusy) |->
		busyCnt_r == 10'd512)
		else $error("Clear sweep length wrong.");
	a_clear_bound: assert property (clearBusy |->
		busyCnt_r < 10'd512)
		else $error("Clear sweep overran.");
	a_reset_quiet: assert property ($fell(sys_rst) |->
		!codeValid && !clearBusy)
		else $error("Outputs active out of reset.");

	c_screen: cover property (codeValid && screenEnd);
	c_line: cover property (codeValid && lineEnd);
	c_clear: cover property ($fell(clearBusy));
	c_hidden: cover property (codeValid && !charVisible && !skipLine
		&& !lineEnd && !screenEnd);
endmodule : opl_loader_sva

bind opl_page_ram_loader opl_loader_sva chk_u (.core_clk, .sys_rst,
	.walkStart, .walkNext, .codeValid, .charCode, .attrCode, .lineEnd,
	.screenEnd, .skipLine, .charVisible, .windowIndex, .clearBusy);

// ===== testbench/opl_host_model.sv
// Host side model that hands serial-bus bytes to the loader.
// Assumes the bench queues whole transfers, address low byte first.
`timescale 1ns/100ps
module opl_host_model (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       byteReady,
	output logic            byteValid,
	output logic [7:0]      byteData,
	output logic            byteFirst
);
	logic [8:0] pendQ[$]; // Queued bytes; bit 8 flags a transfer start.
	logic [1:0] gapCnt;   // Idle edges still owed after an offer.

	initial begin
		byteValid = 1'b0;
		byteData  = 8'h00;
		byteFirst = 1'b0;
	end

	// Leaves two idle edges after each offer, so the ready copy, which
	// trails the buffer by one edge, already counts the last byte taken
	// and no byte is offered to a full buffer; bytes leave in order.
	always @(posedge core_clk) begin
		if (sys_rst) begin
			byteValid <= 1'b0;
			byteFirst <= 1'b0;
			gapCnt    <= 2'h0;
		end else if (byteValid || gapCnt != 2'h0) begin
			byteValid <= 1'b0;
			byteFirst <= 1'b0;
			byteData  <= ~byteData; // Released data keeps changing.
			gapCnt    <= byteValid ? 2'h1 : gapCnt - 2'h1;
		end else if (byteReady && pendQ.size() != 0) begin
			{byteFirst, byteData} <= pendQ.pop_front();
			byteValid <= 1'b1;
		end
	end
endmodule : opl_host_model

// ===== testbench/tb_top.sv
// Self-checking bench for the page memory loader and its byte buffer.
// Assumes the host model feeds bytes and the bench drives the walker.
`timescale 1ns/100ps
module tb_top;
	import opl_pkg::*;
	logic       core_clk = 1'b0, sys_rst = 1'b1, sawFull = 1'b0;
	logic       byteValid, byteFirst, byteReady;
	logic [7:0] byteData, charCode, skipCount;
	logic       walkStart = 1'b0, walkNext = 1'b0, hBlank = 1'b0;
	logic [8:0] walkStartAddr = 9'h000;
	logic       codeValid, lineEnd, screenEnd, skipLine;
	logic       charVisible, windowIndex, clearBusy;
	logic [3:0] attrCode;
	logic [2:0] fontBank;
	int         err_total = 0, cmp_count = 0, cycCnt = 0;

	opl_page_ram_loader dut_u (.core_clk, .sys_rst, .byteValid,
		.byteData, .byteFirst, .byteReady, .walkStart, .walkStartAddr,
		.walkNext, .hBlank, .codeValid, .charCode, .attrCode, .fontBank,
		.lineEnd, .screenEnd, .skipLine, .skipCount, .charVisible,
		.windowIndex, .clearBusy);
	opl_host_model host_u (.core_clk, .sys_rst, .byteReady, .byteValid,
		.byteData, .byteFirst);

	// Makes the 4 ns clock.
	initial begin
		forever #2 core_clk = ~core_clk;
	end

	// Cuts a hang short and notes buffer refusal during a clear.
	always @(posedge core_clk) begin
		cycCnt++;
		if (clearBusy && !byteReady) sawFull <= 1'b1;
		if (cycCnt == 5000) begin
			err_total++;
			wrap_up();
		end
	end

	// Compares one value and reports a mismatch.
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Queues one transfer and waits until the loader has taken it.
	task automatic xfer(input logic [7:0] b[$]);
		int n = 0;
		foreach (b[i]) host_u.pendQ.push_back({i == 0, b[i]});
		while ((host_u.pendQ.size() != 0 || byteValid) && n < 4000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		// A transfer that never drains counts as a mismatch.
		if (n >= 4000) begin
			err_total++;
			wrap_up();
		end
		repeat (4) @(posedge core_clk);
	endtask : xfer

	// Packs one expected word: kind, code, attribute, bank, visible.
	function automatic logic [19:0] e(input logic [3:0] f,
		input logic [7:0] c, input logic [3:0] a, input logic [2:0] k,
		input logic v);
		return {f, c, a, k, v};
	endfunction : e

	// Walks the page from addr and judges every decoded word.
	task automatic walk(input logic [8:0] addr, input logic [19:0] w[$]);
		logic win = 1'b0;
		foreach (w[i]) begin
			@(posedge core_clk);
			hBlank        <= !w[i][0];
			walkStartAddr <= addr;
			if (i == 0) walkStart <= 1'b1;
			else walkNext <= 1'b1;
			@(posedge core_clk);
			walkStart <= 1'b0;
			walkNext  <= 1'b0;
			repeat (3) @(posedge core_clk);
			#1;
			check({codeValid, skipLine, lineEnd, screenEnd}, w[i][19:16]);
			if (w[i][18]) check(skipCount, w[i][15:8]);
			if (w[i][18]) check(windowIndex, win);
			if (w[i][18]) check(attrCode, w[i][7:4]);
			if (w[i][19:16] == 4'h8) begin
				check(charCode, w[i][15:8]);
				check(attrCode, w[i][7:4]);
				check(fontBank, w[i][3:1]);
				check(charVisible, w[i][0]);
			end
			if (w[i][16]) win = ~win;
		end
	endtask : walk

	// Checks the outputs just after reset.
	task automatic t_reset;
		@(posedge core_clk);
		#1;
		check({codeValid, clearBusy, byteReady}, 3'b001);
		$display("test reset done");
	endtask : t_reset

	// Loads two windows over split transfers, sets banks and walks them.
	task automatic t_load;
		xfer('{8'h27, 8'h84, 8'h54, 8'h76});
		xfer('{8'h00, 8'h80, 8'h05, 8'h00, 8'h02, 8'h03, 8'h04, 8'h01,
			8'h00, 8'h05, 8'h06, 8'h07, 8'h00});
		xfer('{8'h0A, 8'h80, 8'h03, 8'h02, 8'h41});
		xfer('{8'h0C, 8'h80, 8'h09, 8'hC2, 8'h00});
		walk(9'h000, '{e(4'hC, 8'h00, 4'h5, 3'h0, 1'b1),
			e(4'h8, 8'h02, 4'h5, 3'h4, 1'b1), e(4'h8, 8'h03, 4'h5, 3'h4, 1'b1),
			e(4'h8, 8'h04, 4'h5, 3'h4, 1'b1), e(4'hA, 8'h01, 4'h5, 3'h0, 1'b1),
			e(4'hC, 8'h00, 4'h5, 3'h0, 1'b1), e(4'h8, 8'h05, 4'h5, 3'h4, 1'b1),
			e(4'h8, 8'h06, 4'h5, 3'h4, 1'b1), e(4'h8, 8'h07, 4'h5, 3'h4, 1'b1),
			e(4'h9, 8'h00, 4'h0, 3'h0, 1'b1), e(4'hC, 8'h02, 4'h3, 3'h0, 1'b1),
			e(4'h8, 8'h41, 4'h3, 3'h5, 1'b0), e(4'h8, 8'hC2, 4'h9, 3'h7, 1'b1),
			e(4'h9, 8'h00, 4'h0, 3'h0, 1'b1)});
		$display("test load done");
	endtask : t_load

	// Clears the page while more bytes pile up behind the sweep.
	task automatic t_clear;
		logic [7:0] q[$];
		int         n = 0;
		q = '{8'h00, 8'h84, 8'h08};
		repeat (20) q.push_back(8'h00);
		xfer(q);
		while (clearBusy && n < 600) begin
			@(posedge core_clk);
			n++;
		end
		check({sawFull, clearBusy}, 2'b10);
		walk(9'h000, '{e(4'hC, 8'h00, 4'h0, 3'h0, 1'b1),
			e(4'h9, 8'h00, 4'h0, 3'h0, 1'b1)});
		$display("test clear done");
	endtask : t_clear

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// Main sequence.
	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_load();
		t_clear();
		wrap_up();
	end
endmodule : tb_top
